/* logic/fcs_pkg.sv */
// Purpose: Constants and types for the bus controller fault/status block.
// Assumes: 125 MHz core clock, 8-bit register addresses, 16-bit registers.
// Notes: Register offsets are byte offsets on the plain register port.
// How it works
// [R01] Alert is OR of enabled unmasked faults
// [R02] Alert drops only after faults cleared; code also drops it on a config write clearing alert enable or a gate bit
// [R03] Masked monitors still flag, no alert/error
// [R04] Config bit 5 gates analog contention
// [R05] Config bit 4 gates digital contention
// [R06] Config bit 3 gates glitch monitor
// [R07] Config bit 2 gates noise monitor
// [R08] Config bit 1 enables redundant reads
// [R09] Config bit 0 enables transaction watchdog
// [R10] State field tracks transaction, writable clear
// [R11] Fault flags set on fault, write-zero clear
// [R12] New transaction never clears fault flags
// [R13] Software waits for error code first
// [R14] State codes 00/01/10/11, writing ones ignored
// [R15] Busy launch, config write, rx read reject
// [R16] Alert enable resets to zero
package fcs_pkg;
    localparam int unsigned FCS_AW = 8;
    localparam int unsigned FCS_DW = 16;
    localparam logic [7:0] FCS_OFF_CONFIG = 8'h89;
    localparam logic [7:0] FCS_OFF_STATUS = 8'h8a;
    localparam logic [7:0] FCS_OFF_LAUNCH = 8'h8f;
    localparam logic [15:0] FCS_CFG_RESET = 16'ha000;
    localparam logic [15:0] FCS_CFG_WMASK = 16'hfc3f;
    localparam int unsigned FCS_CFG_ALERT_EN = 10;
    localparam int unsigned FCS_CFG_ANA = 5;
    localparam int unsigned FCS_CFG_DIG = 4;
    localparam int unsigned FCS_CFG_GLITCH = 3;
    localparam int unsigned FCS_CFG_NOISE = 2;
    localparam int unsigned FCS_CFG_RDTR = 1;
    localparam int unsigned FCS_CFG_WDOG = 0;
    localparam int unsigned FCS_NFLT = 9;
    localparam int unsigned FCS_F_REJECT = 8;
    localparam int unsigned FCS_F_ADDR_NACK = 7;
    localparam int unsigned FCS_F_DATA_NACK = 6;
    localparam int unsigned FCS_F_ANA = 5;
    localparam int unsigned FCS_F_DIG = 4;
    localparam int unsigned FCS_F_GLITCH = 3;
    localparam int unsigned FCS_F_NOISE = 2;
    localparam int unsigned FCS_F_RDTR = 1;
    localparam int unsigned FCS_F_TIMEOUT = 0;
    localparam int unsigned FCS_ST_HI = 15;
    localparam int unsigned FCS_ST_LO = 14;
    localparam logic [8:0] FCS_FLAGS_RESET = 9'h000;
    localparam int unsigned FCS_CLK_MHZ = 125;
    localparam int unsigned FCS_WDOG_US = 10000;
    localparam int unsigned FCS_WDOG_CYC = FCS_WDOG_US * FCS_CLK_MHZ;
    typedef enum logic [1:0] {
        FCS_ST_IDLE = 2'b00,
        FCS_ST_BUSY = 2'b01,
        FCS_ST_DONE = 2'b11,
        FCS_ST_ERROR = 2'b10
    } fcs_txn_state_t;
endpackage : fcs_pkg

/* logic/fcs_pin_sync.sv */
// Purpose: Two-stage synchroniser with edge detection for a link pin.
// Assumes: The pin is asynchronous to clk_sys_i.
// Notes: Only the second stage and its delayed copy feed the edge logic.
`timescale 1ns/10ps
`default_nettype none
module fcs_pin_sync (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic edge_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign edge_o = sync_q ^ prev_q;
endmodule : fcs_pin_sync
`default_nettype wire

/* logic/fcs_watchdog.sv */
// Purpose: Transaction watchdog that fires when the link clock stalls.
// Assumes: active_i is high only while a transaction is in progress.
// Notes: The count restarts on every link clock edge, so a slow but
// live target never trips it.
`timescale 1ns/10ps
`default_nettype none
module fcs_watchdog #(
    parameter int unsigned LIMIT = 1250000
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic active_i,
    input wire logic link_edge_i,
    output logic expired_o
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    logic [CW-1:0] count_q;
    logic fired_q;

    if (LIMIT < 2) begin : g_bad_limit
        $error("fcs_watchdog: LIMIT must be at least 2");
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !enable_i || !active_i || link_edge_i) begin // R09
            count_q <= '0;
            fired_q <= 1'b0;
        end else if (count_q == CW'(LIMIT - 1)) begin
            fired_q <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    assign expired_o = (count_q == CW'(LIMIT - 1)) && !fired_q && enable_i
        && active_i && !link_edge_i;
endmodule : fcs_watchdog
`default_nettype wire

/* logic/fcs_fault_status.sv */
// Purpose: Fault flags, transaction state and alert roll-up of the bus
// controller, with its configuration and status registers.
// Assumes: Engine event inputs are one-cycle pulses on clk_sys_i; the
// link clock pin is asynchronous and is synchronised here.
// Notes: Register reads return data in the cycle after the read strobe.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fcs_fault_status
    import fcs_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = FCS_WDOG_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic link_scl_i,
    input wire logic txn_done_i,
    input wire logic rx_data_read_i,
    input wire logic addr_nack_i,
    input wire logic data_nack_i,
    input wire logic ana_contention_i,
    input wire logic dig_contention_i,
    input wire logic glitch_i,
    input wire logic noise_i,
    input wire logic rr_valid_i,
    input wire logic [7:0] rr_first_i,
    input wire logic [7:0] rr_second_i,
    output logic txn_start_o,
    output logic [15:0] ctrl_config_o,
    output logic redundant_read_en_o,
    output logic summary_bus_alert_flag_o
);
    // The watchdog needs room to count before it can expire.
    if (WDOG_CYCLES < 2) begin : g_bad_wdog
        $error("fcs_fault_status: WDOG_CYCLES must be at least 2");
    end

    logic [15:0] cfg_q;
    logic [8:0] flags_q;
    logic [8:0] flags_d;
    logic [8:0] fault_set;
    logic [8:0] flag_clear;
    logic [8:0] report_mask;
    fcs_txn_state_t state_q;
    fcs_txn_state_t state_d;
    logic err_seen_q;
    logic start_q;
    logic alert_q;
    logic [15:0] rdata_q;
    logic busy;
    logic wr_cfg;
    logic wr_stat;
    logic wr_launch;
    logic reject;
    logic scl_edge;
    logic wdog_expired;

    // Decodes a write strobe against one register offset.
    function automatic logic hit(input logic stb, input logic [7:0] a,
                                 input logic [7:0] off);
        hit = stb && (a == off);
    endfunction : hit

    assign busy = (state_q == FCS_ST_BUSY);
    assign wr_cfg = hit(wr_i, addr_i, FCS_OFF_CONFIG);
    assign wr_stat = hit(wr_i, addr_i, FCS_OFF_STATUS);
    assign wr_launch = hit(wr_i, addr_i, FCS_OFF_LAUNCH);

    fcs_pin_sync u_scl_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(link_scl_i),
        .level_o(),
        .edge_o(scl_edge)
    );

    fcs_watchdog #(
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(cfg_q[FCS_CFG_WDOG]),
        .active_i(busy),
        .link_edge_i(scl_edge),
        .expired_o(wdog_expired)
    );

    // Configuration. Writes during a transaction are dropped and rejected.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cfg_q <= FCS_CFG_RESET; // R16
        end else if (wr_cfg && !busy) begin // R15
            cfg_q <= wdata_i & FCS_CFG_WMASK;
        end
    end

    // Rejected user operations while a transaction is active.
    assign reject = busy && (wr_launch || wr_cfg || rx_data_read_i); // R15

    // Monitors always record their findings; masking acts on reporting.
    always_comb begin
        fault_set = '0;
        fault_set[FCS_F_REJECT] = reject;
        fault_set[FCS_F_ADDR_NACK] = addr_nack_i;
        fault_set[FCS_F_DATA_NACK] = data_nack_i;
        fault_set[FCS_F_ANA] = ana_contention_i; // R03
        fault_set[FCS_F_DIG] = dig_contention_i; // R03
        fault_set[FCS_F_GLITCH] = glitch_i; // R03
        fault_set[FCS_F_NOISE] = noise_i; // R03
        fault_set[FCS_F_RDTR] = cfg_q[FCS_CFG_RDTR] && rr_valid_i
            && (rr_first_i != rr_second_i); // R08
        fault_set[FCS_F_TIMEOUT] = wdog_expired; // R09
    end

    always_comb begin
        report_mask = '1;
        report_mask[FCS_F_ANA] = cfg_q[FCS_CFG_ANA]; // R04
        report_mask[FCS_F_DIG] = cfg_q[FCS_CFG_DIG]; // R05
        report_mask[FCS_F_GLITCH] = cfg_q[FCS_CFG_GLITCH]; // R06
        report_mask[FCS_F_NOISE] = cfg_q[FCS_CFG_NOISE]; // R07
        report_mask[FCS_F_RDTR] = cfg_q[FCS_CFG_RDTR]; // R08
        report_mask[FCS_F_TIMEOUT] = cfg_q[FCS_CFG_WDOG]; // R09
    end

    // A zero written to a flag clears it; ones leave it alone. A fault
    // landing in the same cycle as the clear survives it.
    assign flag_clear = wr_stat ? ~wdata_i[8:0] : '0; // R11
    assign flags_d = (flags_q & ~flag_clear) | fault_set; // R11

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flags_q <= FCS_FLAGS_RESET;
        end else begin
            flags_q <= flags_d; // R12
        end
    end

    // Reported transaction faults decide between complete and error.
    // Rejects concern the user's request, not the running transfer.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            err_seen_q <= 1'b0;
        end else if (wr_launch && !busy) begin
            err_seen_q <= 1'b0;
        end else if (busy && |(fault_set[7:0] & report_mask[7:0])) begin
            err_seen_q <= 1'b1; // R03
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            FCS_ST_BUSY: begin
                if (txn_done_i) begin
                    state_d = (err_seen_q
                        || |(fault_set[7:0] & report_mask[7:0]))
                        ? FCS_ST_ERROR : FCS_ST_DONE; // R14
                end
            end
            default: begin
                if (wr_launch) begin
                    state_d = FCS_ST_BUSY; // R10
                end else if (wr_stat
                             && wdata_i[FCS_ST_HI:FCS_ST_LO] == 2'b00) begin
                    state_d = FCS_ST_IDLE; // R14
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= FCS_ST_IDLE;
        end else begin
            state_q <= state_d; // R10
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= wr_launch && !busy;
        end
    end

    // Alert follows the recorded flags, so it drops once software has cleared every
    // reportable flag and nothing new has arrived, or once a config write clears the
    // alert enable or the gate bits of the flagged monitors.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= cfg_q[FCS_CFG_ALERT_EN]
                && |(flags_q & report_mask); // R01 R02
        end
    end

    // Read data stands for one cycle only; unmapped offsets read zero.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !rd_i) begin
            rdata_q <= '0;
        end else if (addr_i == FCS_OFF_CONFIG) begin
            rdata_q <= cfg_q;
        end else if (addr_i == FCS_OFF_STATUS) begin
            rdata_q <= {state_q, 5'h00, flags_q};
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;
    assign txn_start_o = start_q;
    assign ctrl_config_o = cfg_q;
    assign redundant_read_en_o = cfg_q[FCS_CFG_RDTR]; // R08
    assign summary_bus_alert_flag_o = alert_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_launch_idle;
        wr_launch && !busy;
    endsequence

    sequence s_started;
        state_q == FCS_ST_BUSY && txn_start_o;
    endsequence

    a_alert_disabled: assert property ( // R01
        !cfg_q[FCS_CFG_ALERT_EN] |=> !summary_bus_alert_flag_o)
        else $error("alert raised while alert enable is clear");

    a_alert_cleared: assert property ( // R02
        flags_q == '0 |=> !summary_bus_alert_flag_o)
        else $error("alert stands with no flags recorded");

    a_masked_silent: assert property ( // R03
        (flags_q & report_mask) == '0 |=> !summary_bus_alert_flag_o)
        else $error("masked fault raised the alert");

    a_noise_flag_kept: assert property ( // R07
        noise_i && !cfg_q[FCS_CFG_NOISE] |=> flags_q[FCS_F_NOISE])
        else $error("masked noise fault not recorded");

    a_flags_sticky: assert property ( // R12
        !wr_stat |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("fault flag lost without a status write");

    a_launch_starts: assert property ( // R10
        s_launch_idle |=> s_started ##1 !txn_start_o)
        else $error("launch did not start a single transaction");

    a_busy_reject: assert property ( // R15
        wr_launch && busy && !txn_done_i |=> flags_q[FCS_F_REJECT] && busy)
        else $error("launch during transaction not rejected");

    a_cfg_protected: assert property ( // R15
        wr_cfg && busy |=> cfg_q == $past(cfg_q))
        else $error("config changed during transaction");

    a_error_code: assert property ( // R14
        busy && err_seen_q && txn_done_i |=> state_q == FCS_ST_ERROR)
        else $error("faulted transaction not reported as error");

    a_wdog_off: assert property ( // R09
        !cfg_q[FCS_CFG_WDOG] |=> !$rose(flags_q[FCS_F_TIMEOUT]))
        else $error("timeout fault with watchdog disabled");

    a_state_ones: assert property ( // R14
        wr_stat && !busy && wdata_i[FCS_ST_HI:FCS_ST_LO] != 2'b00
        |=> state_q == $past(state_q))
        else $error("writing ones changed the state field");

    a_flag_clear: assert property ( // R11
        wr_stat && fault_set == '0
        |=> flags_q == ($past(flags_q) & $past(wdata_i[8:0])))
        else $error("status write did not clear the zeroed flags");

    a_clean_done: assert property ( // R03
        busy && txn_done_i && !err_seen_q
        && (fault_set[7:0] & report_mask[7:0]) == '0
        |=> state_q == FCS_ST_DONE)
        else $error("clean transaction not reported as complete");

    a_rr_off: assert property ( // R08
        !cfg_q[FCS_CFG_RDTR] |=> !$rose(flags_q[FCS_F_RDTR]))
        else $error("read mismatch flagged with check disabled");

    a_ana_flag_kept: assert property ( // R04
        ana_contention_i && !cfg_q[FCS_CFG_ANA] |=> flags_q[FCS_F_ANA])
        else $error("masked analog contention not recorded");

    a_dig_flag_kept: assert property ( // R05
        dig_contention_i && !cfg_q[FCS_CFG_DIG] |=> flags_q[FCS_F_DIG])
        else $error("masked digital contention not recorded");

    a_glitch_flag_kept: assert property ( // R06
        glitch_i && !cfg_q[FCS_CFG_GLITCH] |=> flags_q[FCS_F_GLITCH])
        else $error("masked glitch fault not recorded");

    a_alert_raised: assert property ( // R01
        cfg_q[FCS_CFG_ALERT_EN] && (flags_q & report_mask) != '0
        |=> summary_bus_alert_flag_o)
        else $error("reportable fault did not raise the alert");
endmodule : fcs_fault_status
`default_nettype wire

/* tb/fcs_target_model.sv */
// Purpose: Bus target side: link clock frames, address nack, done pulse.
// Assumes: The clock line idles high through its pull-up.
// Notes: A stall holds the clock low long enough to trip a short watchdog.
`timescale 1ns/10ps
`default_nettype none
module fcs_target_model (
    input wire logic clk_sys_i,
    input wire logic start_i,
    input wire logic stall_i,
    input wire logic nack_i,
    output logic scl_o,
    output logic done_o,
    output logic nack_o
);
    initial begin
        scl_o = 1'b1;
        done_o = 1'b0;
        nack_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            #1;
            if (start_i === 1'b1) begin
                // Off the core clock grid so the link phase is unrelated.
                #5;
                if (stall_i === 1'b1) begin
                    scl_o = 1'b0;
                    repeat (80) @(posedge clk_sys_i);
                    scl_o = 1'b1;
                end else begin
                    repeat (16) #32 scl_o = ~scl_o;
                end
                @(posedge clk_sys_i);
                nack_o <= nack_i;
                @(posedge clk_sys_i);
                nack_o <= 1'b0;
                done_o <= 1'b1;
                @(posedge clk_sys_i);
                done_o <= 1'b0;
            end
        end
    end
endmodule : fcs_target_model
`default_nettype wire

/* tb/fcs_fault_status_tb_top.sv */
// Purpose: Self-checking bench for the fault and status block.
// Assumes: Watchdog shortened to 50 cycles.
// Notes: The target model supplies link clock, nack and done.
`timescale 1ns/10ps
`default_nettype none
module fcs_fault_status_tb_top import fcs_pkg::*; ;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rx_rd = 1'b0;
    logic dnack = 1'b0;
    logic [5:2] mon = 4'h0;
    logic rr_v = 1'b0;
    logic [7:0] rr_a = 8'h00;
    logic [7:0] rr_b = 8'h00;
    logic stall = 1'b0;
    logic nack = 1'b0;
    logic [15:0] rdata, cfg;
    logic scl, done, anack, start, rr_en, alert;
    int miscompares = 0;
    int total_checks = 0;
    int starts = 0;
    int cycles = 0;

    fcs_fault_status #(.WDOG_CYCLES(50)) fcs_fault_status_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .link_scl_i(scl), .txn_done_i(done), .rx_data_read_i(rx_rd),
        .addr_nack_i(anack), .data_nack_i(dnack),
        .ana_contention_i(mon[5]), .dig_contention_i(mon[4]),
        .glitch_i(mon[3]), .noise_i(mon[2]), .rr_valid_i(rr_v),
        .rr_first_i(rr_a), .rr_second_i(rr_b), .txn_start_o(start),
        .ctrl_config_o(cfg), .redundant_read_en_o(rr_en),
        .summary_bus_alert_flag_o(alert));
    fcs_target_model fcs_target_model_inst (
        .clk_sys_i(clk_sys_i), .start_i(start), .stall_i(stall),
        .nack_i(nack), .scl_o(scl), .done_o(done), .nack_o(anack));

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (start === 1'b1) starts++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 q = rdata;
    endtask : rd
    task automatic pulse(input logic [5:2] m);
        @(posedge clk_sys_i);
        mon <= m;
        @(posedge clk_sys_i);
        mon <= 4'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : pulse
    task automatic rr(input logic [7:0] a, b, input logic [15:0] e);
        logic [15:0] q;
        @(posedge clk_sys_i);
        rr_v <= 1'b1;
        rr_a <= a;
        rr_b <= b;
        @(posedge clk_sys_i);
        rr_v <= 1'b0;
        rd(FCS_OFF_STATUS, q);
        chk("rr flag", q, e);
    endtask : rr
    task automatic wait_st(input logic [1:0] s, output logic [15:0] q);
        for (int k = 0; k < 100; k++) begin
            rd(FCS_OFF_STATUS, q);
            if (q[15:14] === s) return;
        end
    endtask : wait_st

    task automatic t_reset();
        logic [15:0] q;
        rd(FCS_OFF_CONFIG, q);
        chk("config reset", q, 16'ha000);
        chk("config out", cfg, 16'ha000);
        rd(FCS_OFF_STATUS, q);
        chk("status reset", q, 16'h0000);
        rd(8'h00, q);
        chk("unmapped", q, 16'h0000);
        chk("alert reset", {15'h0, alert}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_monitors();
        logic [15:0] q;
        wr(FCS_OFF_CONFIG, 16'h0400);
        pulse(4'hf);
        rd(FCS_OFF_STATUS, q);
        chk("masked flags", q, 16'h003c);
        chk("masked alert", {15'h0, alert}, 16'h0000);
        wr(FCS_OFF_STATUS, 16'h0000);
        for (int i = 2; i < 6; i++) begin
            wr(FCS_OFF_CONFIG, 16'h0400 | (16'h0001 << i));
            pulse(4'h1 << (i - 2));
            chk("alert", {15'h0, alert}, 16'h0001);
            wr(FCS_OFF_STATUS, 16'hffff);
            chk("alert held", {15'h0, alert}, 16'h0001);
            wr(FCS_OFF_STATUS, 16'h0000);
            repeat (2) @(posedge clk_sys_i);
            chk("alert off", {15'h0, alert}, 16'h0000);
        end
        wr(FCS_OFF_CONFIG, 16'h003c);
        pulse(4'hf);
        chk("alert gated", {15'h0, alert}, 16'h0000);
        wr(FCS_OFF_STATUS, 16'h0000);
        $display("test monitors done");
    endtask : t_monitors
    task automatic t_txn();
        logic [15:0] q;
        wr(FCS_OFF_CONFIG, 16'h0400);
        wr(FCS_OFF_LAUNCH, 16'h0000);
        wr(FCS_OFF_CONFIG, 16'h0001);
        rd(FCS_OFF_CONFIG, q);
        chk("busy config", q, 16'h0400);
        rd(FCS_OFF_STATUS, q);
        chk("busy reject", q, 16'h4100);
        wr(FCS_OFF_STATUS, 16'h0000);
        wr(FCS_OFF_LAUNCH, 16'h0000);
        rd(FCS_OFF_STATUS, q);
        chk("launch reject", q, 16'h4100);
        chk("starts", 16'(starts), 16'h0001);
        wr(FCS_OFF_STATUS, 16'h0000);
        @(posedge clk_sys_i);
        rx_rd <= 1'b1;
        @(posedge clk_sys_i);
        rx_rd <= 1'b0;
        rd(FCS_OFF_STATUS, q);
        chk("rx reject", q, 16'h4100);
        chk("reject alert", {15'h0, alert}, 16'h0001);
        wait_st(FCS_ST_DONE, q);
        chk("done", q, 16'hc100);
        wr(FCS_OFF_STATUS, 16'hc1ff);
        rd(FCS_OFF_STATUS, q);
        chk("ones ignored", q, 16'hc100);
        wr(FCS_OFF_STATUS, 16'h0000);
        rd(FCS_OFF_STATUS, q);
        chk("cleared", q, 16'h0000);
        $display("test transaction done");
    endtask : t_txn
    task automatic t_error();
        logic [15:0] q;
        nack <= 1'b1;
        wr(FCS_OFF_LAUNCH, 16'h0000);
        @(posedge clk_sys_i);
        dnack <= 1'b1;
        @(posedge clk_sys_i);
        dnack <= 1'b0;
        wait_st(FCS_ST_ERROR, q);
        chk("error", q, 16'h80c0);
        nack <= 1'b0;
        wr(FCS_OFF_LAUNCH, 16'h0000);
        wait_st(FCS_ST_DONE, q);
        chk("accumulate", q, 16'hc0c0);
        wr(FCS_OFF_STATUS, 16'h0000);
        $display("test error done");
    endtask : t_error
    task automatic t_redund();
        wr(FCS_OFF_CONFIG, 16'h0000);
        rr(8'h5a, 8'h5b, 16'h0000);
        wr(FCS_OFF_CONFIG, 16'h0002);
        chk("rr enable", {15'h0, rr_en}, 16'h0001);
        rr(8'h5a, 8'h5a, 16'h0000);
        rr(8'h00, 8'h80, 16'h0002);
        wr(FCS_OFF_STATUS, 16'h0000);
        $display("test redundant done");
    endtask : t_redund
    task automatic t_wdog();
        logic [15:0] q;
        stall <= 1'b1;
        wr(FCS_OFF_CONFIG, 16'h0000);
        wr(FCS_OFF_LAUNCH, 16'h0000);
        pulse(4'h1);
        wait_st(FCS_ST_DONE, q);
        chk("no watchdog", q, 16'hc004);
        wr(FCS_OFF_STATUS, 16'h0000);
        wr(FCS_OFF_CONFIG, 16'h0001);
        wr(FCS_OFF_LAUNCH, 16'h0000);
        wait_st(FCS_ST_ERROR, q);
        chk("timeout", q, 16'h8001);
        stall <= 1'b0;
        $display("test watchdog done");
    endtask : t_wdog

    initial begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_monitors();
        t_txn();
        t_error();
        t_redund();
        t_wdog();
        wrap_up();
    end
endmodule : fcs_fault_status_tb_top
`default_nettype wire
